// *** verilog/rmdec_decoder.sv ***
// How it works
// [RQ1] Core has ten addressing modes; this block decodes the six register/memory forms
// [RQ2] Indexed no-offset is one byte; no instruction here exceeds three bytes
// [RQ3] Extended form carries a full 16-bit address reaching all memory
// [RQ4] Each form yields an effective address for operand read or write
// [RQ5] High nibble picks form: A imm, B dir, C ext, F ix0, E ix1, D ix2
// [RQ6] Low nibble picks the operation, sixteen codes from subtract to store index
// [RQ7] Read ops: lengths 2,2,3,1,2,3 bytes and cycles 2,3,4,3,4,5
// [RQ8] Bit test ANDs for flags only, accumulator stays unchanged
// [RQ9] Add with carry adds operand and carry into the accumulator
// [RQ10] No immediate store or jump; store +1 cycle, jump -1, call +2
// [RQ11] Jumps use only the effective address, no register operand
// [RQ12] Direct mode: high address byte zero, low byte from the operand
// [RQ13] Immediate operand is the byte after opcode; program counter advances two
module rmdec_decoder (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic decode_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand_byte1,
    input wire logic [7:0] operand_byte2,
    input wire logic [15:0] program_counter,
    input wire logic [7:0] index_value,
    input wire logic carry_flag,
    output rmdec_pkg::rmdec_result_s result
);
    rmdec_pkg::rmdec_result_s result_reg;
    rmdec_pkg::rmdec_result_s result_next;

    // Form from the high nibble; other nibbles belong to other groups
    function automatic rmdec_pkg::rmdec_mode_e mode_of(input logic [3:0] nib);
        unique case (nib)
            rmdec_pkg::RMDEC_NIB_IMM: mode_of = rmdec_pkg::RMDEC_MODE_IMM; // RQ5
            rmdec_pkg::RMDEC_NIB_DIR: mode_of = rmdec_pkg::RMDEC_MODE_DIR; // RQ5
            rmdec_pkg::RMDEC_NIB_EXT: mode_of = rmdec_pkg::RMDEC_MODE_EXT; // RQ5
            rmdec_pkg::RMDEC_NIB_IX2: mode_of = rmdec_pkg::RMDEC_MODE_IX2; // RQ5
            rmdec_pkg::RMDEC_NIB_IX1: mode_of = rmdec_pkg::RMDEC_MODE_IX1; // RQ5
            rmdec_pkg::RMDEC_NIB_IX0: mode_of = rmdec_pkg::RMDEC_MODE_IX0; // RQ5
            default: mode_of = rmdec_pkg::RMDEC_MODE_NONE;
        endcase
    endfunction

    function automatic logic [1:0] length_of(input rmdec_pkg::rmdec_mode_e m);
        unique case (m)
            rmdec_pkg::RMDEC_MODE_IX0: length_of = 2'd1; // RQ2
            rmdec_pkg::RMDEC_MODE_EXT,
            rmdec_pkg::RMDEC_MODE_IX2: length_of = rmdec_pkg::RMDEC_MAX_BYTES; // RQ2
            rmdec_pkg::RMDEC_MODE_NONE: length_of = 2'd0;
            default: length_of = 2'd2; // RQ7
        endcase
    endfunction

    function automatic logic [2:0] base_cycles(input rmdec_pkg::rmdec_mode_e m);
        unique case (m)
            rmdec_pkg::RMDEC_MODE_IMM: base_cycles = rmdec_pkg::RMDEC_CYC_IMM; // RQ7
            rmdec_pkg::RMDEC_MODE_DIR: base_cycles = rmdec_pkg::RMDEC_CYC_DIR; // RQ7
            rmdec_pkg::RMDEC_MODE_EXT: base_cycles = rmdec_pkg::RMDEC_CYC_EXT; // RQ7
            rmdec_pkg::RMDEC_MODE_IX0: base_cycles = rmdec_pkg::RMDEC_CYC_IX0; // RQ7
            rmdec_pkg::RMDEC_MODE_IX1: base_cycles = rmdec_pkg::RMDEC_CYC_IX1; // RQ7
            rmdec_pkg::RMDEC_MODE_IX2: base_cycles = rmdec_pkg::RMDEC_CYC_IX2; // RQ7
            default: base_cycles = 3'd0;
        endcase
    endfunction

    rmdec_pkg::rmdec_mode_e mode;
    rmdec_pkg::rmdec_op_e op;
    logic is_store;
    logic is_jump;
    logic is_call;
    logic illegal;
    logic [15:0] ix_sum1;
    logic [15:0] ix_sum2;

    assign mode = mode_of(opcode[7:4]); // RQ1
    assign op = rmdec_pkg::rmdec_op_e'(opcode[3:0]); // RQ6
    assign is_store = (op == rmdec_pkg::RMDEC_OP_STORE_ACCUMULATOR) ||
        (op == rmdec_pkg::RMDEC_OP_STORE_INDEX);
    assign is_jump = (op == rmdec_pkg::RMDEC_OP_JUMP_UNCONDITIONAL);
    assign is_call = (op == rmdec_pkg::RMDEC_OP_JUMP_TO_SUBROUTINE);
    // Immediate stores and jumps have no meaning; other opcode groups too
    assign illegal = (mode == rmdec_pkg::RMDEC_MODE_NONE) ||
        ((mode == rmdec_pkg::RMDEC_MODE_IMM) && (is_store || is_jump || is_call)); // RQ10
    // Index is unsigned, so offsets only add upward
    assign ix_sum1 = {8'h00, operand_byte1} + {8'h00, index_value};
    assign ix_sum2 = {operand_byte1, operand_byte2} + {8'h00, index_value};

    always_comb begin
        result_next = '0;
        result_next.valid = decode_valid;
        result_next.illegal = decode_valid && illegal;
        result_next.op = op;
        result_next.mode = mode;
        result_next.imm = operand_byte1;
        unique case (mode)
            rmdec_pkg::RMDEC_MODE_IMM: begin
                result_next.src = rmdec_pkg::RMDEC_SRC_OPERAND;
                result_next.effective_address = program_counter + 16'h0001; // RQ13
            end
            rmdec_pkg::RMDEC_MODE_DIR: begin
                result_next.src = rmdec_pkg::RMDEC_SRC_ZERO_PAGE;
                result_next.effective_address = {rmdec_pkg::RMDEC_ZERO_PAGE_HIGH,
                    operand_byte1}; // RQ12
            end
            rmdec_pkg::RMDEC_MODE_EXT: begin
                result_next.src = rmdec_pkg::RMDEC_SRC_ABSOLUTE;
                result_next.effective_address = {operand_byte1, operand_byte2}; // RQ3
            end
            rmdec_pkg::RMDEC_MODE_IX0: begin
                result_next.src = rmdec_pkg::RMDEC_SRC_INDEXED;
                result_next.effective_address = {8'h00, index_value}; // RQ4
            end
            rmdec_pkg::RMDEC_MODE_IX1: begin
                result_next.src = rmdec_pkg::RMDEC_SRC_INDEXED;
                result_next.effective_address = ix_sum1; // RQ4
            end
            rmdec_pkg::RMDEC_MODE_IX2: begin
                result_next.src = rmdec_pkg::RMDEC_SRC_INDEXED;
                result_next.effective_address = ix_sum2; // RQ4
            end
            default: begin
                result_next.src = rmdec_pkg::RMDEC_SRC_OPERAND;
                result_next.effective_address = rmdec_pkg::RMDEC_ADDR_RESET;
            end
        endcase
        result_next.length = illegal ? 2'd0 : length_of(mode); // RQ2
        result_next.program_counter_next = program_counter +
            {14'h0000, result_next.length}; // RQ13
        if (illegal) begin
            result_next.cycles = 3'd0;
        end else if (is_store) begin
            result_next.cycles = base_cycles(mode) + rmdec_pkg::RMDEC_CYC_STORE_EXTRA; // RQ10
        end else if (is_jump) begin
            result_next.cycles = base_cycles(mode) - rmdec_pkg::RMDEC_CYC_JUMP_LESS; // RQ10
        end else if (is_call) begin
            result_next.cycles = base_cycles(mode) + rmdec_pkg::RMDEC_CYC_CALL_EXTRA; // RQ10
        end else begin
            result_next.cycles = base_cycles(mode); // RQ7
        end
        result_next.is_jump = is_jump || is_call; // RQ11
        result_next.is_call = is_call;
        // Jumps take no register operand
        result_next.uses_index = !illegal && ((op == rmdec_pkg::RMDEC_OP_COMPARE_INDEX) ||
            (op == rmdec_pkg::RMDEC_OP_LOAD_INDEX) ||
            (op == rmdec_pkg::RMDEC_OP_STORE_INDEX)); // RQ11
        result_next.uses_accumulator = !illegal && !result_next.uses_index &&
            !is_jump && !is_call; // RQ11
        result_next.writes_memory = !illegal && is_store;
        // Compares and bit test only set flags
        result_next.writes_register = !illegal && !is_store && !is_jump && !is_call &&
            (op != rmdec_pkg::RMDEC_OP_COMPARE_ACCUMULATOR) &&
            (op != rmdec_pkg::RMDEC_OP_COMPARE_INDEX) &&
            (op != rmdec_pkg::RMDEC_OP_BIT_TEST); // RQ8
        result_next.writes_flags = !illegal && !is_jump && !is_call;
        result_next.carry_in = (op == rmdec_pkg::RMDEC_OP_ADD_WITH_CARRY) ||
            (op == rmdec_pkg::RMDEC_OP_SUBTRACT_WITH_BORROW) ? carry_flag : 1'b0; // RQ9
        if (!decode_valid) begin
            result_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            result_reg <= '0;
        end else begin
            result_reg <= result_next;
        end
    end

    assign result = result_reg;

    // A legal answer always has a length, so a zero length marks a refused opcode
    a_len_legal: assert property (@(posedge clock) disable iff (sys_rst) // RQ2
        (result.valid && !result.illegal) |-> (result.length != 2'd0))
        else $error("legal opcode with zero length");
    a_ix0_len: assert property (@(posedge clock) disable iff (sys_rst) // RQ2
        (decode_valid && opcode[7:4] == 4'hF) |=> (result.length == 2'd1))
        else $error("indexed no offset not one byte");
    a_ext_addr: assert property (@(posedge clock) disable iff (sys_rst) // RQ3
        (decode_valid && opcode[7:4] == 4'hC) |=>
        (result.effective_address == {$past(operand_byte1), $past(operand_byte2)}))
        else $error("extended address wrong");
    a_ix1_addr: assert property (@(posedge clock) disable iff (sys_rst) // RQ4
        (decode_valid && opcode[7:4] == 4'hE) |=>
        (result.effective_address ==
        16'({8'h00, $past(operand_byte1)} + {8'h00, $past(index_value)})))
        else $error("indexed offset address wrong");
    a_dir_page: assert property (@(posedge clock) disable iff (sys_rst) // RQ12
        (decode_valid && opcode[7:4] == 4'hB) |=>
        (result.effective_address[15:8] == 8'h00 &&
        result.effective_address[7:0] == $past(operand_byte1)))
        else $error("direct address not page zero");
    a_imm_advance: assert property (@(posedge clock) disable iff (sys_rst) // RQ13
        (decode_valid && opcode == 8'hA6) |=>
        (result.program_counter_next == 16'($past(program_counter) + 16'h0002)))
        else $error("immediate did not advance two");
    a_mode_op: assert property (@(posedge clock) disable iff (sys_rst) // RQ5
        (decode_valid && opcode == 8'hD2) |=> (result.mode == rmdec_pkg::RMDEC_MODE_IX2 &&
        result.op == rmdec_pkg::RMDEC_OP_SUBTRACT_WITH_BORROW))
        else $error("opcode split wrong");
    a_index_load: assert property (@(posedge clock) disable iff (sys_rst) // RQ6
        (decode_valid && opcode == 8'hDE) |=> (result.cycles == 3'd5 && result.uses_index))
        else $error("load index ix2 wrong");
    a_read_cycles: assert property (@(posedge clock) disable iff (sys_rst) // RQ7
        (decode_valid && opcode == 8'hC6) |=> (result.cycles == 3'd4 && result.length == 2'd3))
        else $error("extended load cycles wrong");
    a_bit_noacc: assert property (@(posedge clock) disable iff (sys_rst) // RQ8
        (decode_valid && opcode[3:0] == 4'h5) |=> !result.writes_register)
        else $error("bit test writes accumulator");
    a_adc_carry: assert property (@(posedge clock) disable iff (sys_rst) // RQ9
        (decode_valid && opcode == 8'hB9) |=> (result.carry_in == $past(carry_flag) &&
        result.writes_register))
        else $error("carry not passed");
    a_no_imm_st: assert property (@(posedge clock) disable iff (sys_rst) // RQ10
        (decode_valid && (opcode == 8'hA7 || opcode == 8'hAC)) |=> result.illegal)
        else $error("immediate store accepted");
    a_call_cycles: assert property (@(posedge clock) disable iff (sys_rst) // RQ11
        (decode_valid && opcode == 8'hDD) |=> (result.cycles == 3'd7 && result.is_call &&
        !result.uses_accumulator && !result.uses_index))
        else $error("call decode wrong");
    a_form_found: assert property (@(posedge clock) disable iff (sys_rst) // RQ1
        (decode_valid && opcode[7:4] >= 4'hA) |=>
        (result.mode != rmdec_pkg::RMDEC_MODE_NONE))
        else $error("group opcode without a form");
endmodule

// *** verilog/rmdec_pkg.sv ***
package rmdec_pkg;
    typedef enum logic [2:0] {
        RMDEC_MODE_NONE = 3'b000,
        RMDEC_MODE_IMM = 3'b001,
        RMDEC_MODE_DIR = 3'b010,
        RMDEC_MODE_EXT = 3'b011,
        RMDEC_MODE_IX0 = 3'b100,
        RMDEC_MODE_IX1 = 3'b101,
        RMDEC_MODE_IX2 = 3'b110
    } rmdec_mode_e;

    typedef enum logic [3:0] {
        RMDEC_OP_SUBTRACT = 4'h0,
        RMDEC_OP_COMPARE_ACCUMULATOR = 4'h1,
        RMDEC_OP_SUBTRACT_WITH_BORROW = 4'h2,
        RMDEC_OP_COMPARE_INDEX = 4'h3,
        RMDEC_OP_AND = 4'h4,
        RMDEC_OP_BIT_TEST = 4'h5,
        RMDEC_OP_LOAD_ACCUMULATOR = 4'h6,
        RMDEC_OP_STORE_ACCUMULATOR = 4'h7,
        RMDEC_OP_EXCLUSIVE_OR_ACCUMULATOR = 4'h8,
        RMDEC_OP_ADD_WITH_CARRY = 4'h9,
        RMDEC_OP_OR_ACCUMULATOR = 4'hA,
        RMDEC_OP_ADD = 4'hB,
        RMDEC_OP_JUMP_UNCONDITIONAL = 4'hC,
        RMDEC_OP_JUMP_TO_SUBROUTINE = 4'hD,
        RMDEC_OP_LOAD_INDEX = 4'hE,
        RMDEC_OP_STORE_INDEX = 4'hF
    } rmdec_op_e;

    // Address source of the effective address
    typedef enum logic [1:0] {
        RMDEC_SRC_OPERAND = 2'b00,
        RMDEC_SRC_ZERO_PAGE = 2'b01,
        RMDEC_SRC_ABSOLUTE = 2'b10,
        RMDEC_SRC_INDEXED = 2'b11
    } rmdec_src_e;

    localparam logic [3:0] RMDEC_NIB_IMM = 4'hA;
    localparam logic [3:0] RMDEC_NIB_DIR = 4'hB;
    localparam logic [3:0] RMDEC_NIB_EXT = 4'hC;
    localparam logic [3:0] RMDEC_NIB_IX2 = 4'hD;
    localparam logic [3:0] RMDEC_NIB_IX1 = 4'hE;
    localparam logic [3:0] RMDEC_NIB_IX0 = 4'hF;
    localparam int RMDEC_NUM_MODES = 10;
    localparam logic [1:0] RMDEC_MAX_BYTES = 2'd3;
    localparam logic [15:0] RMDEC_COUNTER_RESET = 16'h0000;
    localparam logic [15:0] RMDEC_ADDR_RESET = 16'h0000;
    localparam logic [7:0] RMDEC_BYTE_RESET = 8'h00;
    localparam logic [7:0] RMDEC_ZERO_PAGE_HIGH = 8'h00;
    // Base cycle counts for read operations, per mode, then the store, jump and call adjustments
    localparam logic [2:0] RMDEC_CYC_IMM = 3'd2;
    localparam logic [2:0] RMDEC_CYC_DIR = 3'd3;
    localparam logic [2:0] RMDEC_CYC_EXT = 3'd4;
    localparam logic [2:0] RMDEC_CYC_IX0 = 3'd3;
    localparam logic [2:0] RMDEC_CYC_IX1 = 3'd4;
    localparam logic [2:0] RMDEC_CYC_IX2 = 3'd5;
    localparam logic [2:0] RMDEC_CYC_STORE_EXTRA = 3'd1;
    localparam logic [2:0] RMDEC_CYC_JUMP_LESS = 3'd1;
    localparam logic [2:0] RMDEC_CYC_CALL_EXTRA = 3'd2;

    typedef struct packed {
        logic valid;
        logic illegal;
        rmdec_op_e op;
        rmdec_mode_e mode;
        rmdec_src_e src;
        logic [1:0] length;
        logic [2:0] cycles;
        logic [15:0] effective_address;
        logic [15:0] program_counter_next;
        logic [7:0] imm;
        logic uses_accumulator;
        logic uses_index;
        logic writes_register;
        logic writes_memory;
        logic writes_flags;
        logic carry_in;
        logic is_jump;
        logic is_call;
    } rmdec_result_s;
endpackage

// *** verification/rmdec_fetch_model.sv ***
module rmdec_fetch_model (
    input wire logic [15:0] program_counter,
    input wire logic [7:0] opcode_sel,
    output logic [7:0] opcode,
    output logic [7:0] operand_byte1,
    output logic [7:0] operand_byte2
);
    timeunit 1ns;
    timeprecision 1ns;
    // Opcode chosen by the bench, the bytes after it follow from the fetch address
    assign opcode = opcode_sel;
    // Byte after the opcode; chosen so that high offsets and wraps are easy to hit
    assign operand_byte1 = program_counter[7:0] + 8'h01;
    assign operand_byte2 = program_counter[15:8];
endmodule

// *** verification/rmdec_decoder_tb.sv ***
module rmdec_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic decode_valid = 1'b0;
    logic carry_flag = 1'b0;
    logic [7:0] opcode_sel = 8'h00;
    logic [7:0] index_value = 8'h00;
    logic [15:0] program_counter = 16'h0000;
    logic [7:0] opcode;
    logic [7:0] operand_byte1;
    logic [7:0] operand_byte2;
    rmdec_pkg::rmdec_result_s result;
    int fails = 0;
    int checked = 0;

    always #50 clock = ~clock;

    rmdec_fetch_model rmdec_fetch_model_inst (.program_counter(program_counter),
        .opcode_sel(opcode_sel), .opcode(opcode), .operand_byte1(operand_byte1),
        .operand_byte2(operand_byte2));
    rmdec_decoder rmdec_decoder_inst (.clock(clock), .sys_rst(sys_rst),
        .decode_valid(decode_valid), .opcode(opcode), .operand_byte1(operand_byte1),
        .operand_byte2(operand_byte2), .program_counter(program_counter),
        .index_value(index_value), .carry_flag(carry_flag), .result(result));

    task automatic check_value(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_result(input rmdec_pkg::rmdec_result_s got,
                                input rmdec_pkg::rmdec_result_s exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Drives one request, then judges the answer 1 ns after the edge that takes it
    task automatic issue(input logic [7:0] op, input logic [15:0] addr, input logic [7:0] idx,
                         input logic cy);
        logic [3:0] h;
        logic [3:0] l;
        logic ill;
        logic branch;
        logic store;
        logic idx_op;
        logic flags_only;
        logic [1:0] len;
        logic [2:0] cyc;
        logic [2:0] md;
        logic [1:0] src;
        logic [15:0] want;
        logic [7:0] b1;
        logic [7:0] b2;
        h = op[7:4];
        l = op[3:0];
        opcode_sel = op;
        program_counter = addr;
        index_value = idx;
        carry_flag = cy;
        decode_valid = 1'b1;
        @(posedge clock);
        b1 = operand_byte1;
        b2 = operand_byte2;
        #1;
        branch = (l[3:1] == 3'b110);
        store = (l == 4'h7) || (l == 4'hF);
        idx_op = (l == 4'h3) || (l == 4'hE) || (l == 4'hF);
        flags_only = (l == 4'h1) || (l == 4'h3) || (l == 4'h5);
        ill = (h < 4'hA) || (h == 4'hA && (store || branch));
        len = 2'd0;
        cyc = 3'd0;
        md = 3'd0;
        src = 2'd3;
        want = 16'h0000;
        case (h)
            4'hA: begin
                len = 2'd2;
                cyc = 3'd2;
                md = 3'd1;
                src = 2'd0;
                want = addr + 16'h0001;
            end
            4'hB: begin
                len = 2'd2;
                cyc = 3'd3;
                md = 3'd2;
                src = 2'd1;
                want = {8'h00, b1};
            end
            4'hC: begin
                len = 2'd3;
                cyc = 3'd4;
                md = 3'd3;
                src = 2'd2;
                want = {b1, b2};
            end
            4'hD: begin
                len = 2'd3;
                cyc = 3'd5;
                md = 3'd6;
                want = {b1, b2} + {8'h00, idx};
            end
            4'hE: begin
                len = 2'd2;
                cyc = 3'd4;
                md = 3'd5;
                want = {8'h00, b1} + {8'h00, idx};
            end
            4'hF: begin
                len = 2'd1;
                cyc = 3'd3;
                md = 3'd4;
                want = {8'h00, idx};
            end
            default: begin
            end
        endcase
        if (store) cyc = cyc + 3'd1;
        if (l == 4'hC) cyc = cyc - 3'd1;
        if (l == 4'hD) cyc = cyc + 3'd2;
        if (ill) begin
            check_value(16'(result.valid), 16'h0001);
            check_value(16'(result.illegal), 16'h0001);
            check_value(16'(result.length), 16'h0000);
            check_value(16'(result.cycles), 16'h0000);
            return;
        end
        check_value(16'(result.valid), 16'h0001);
        check_value(16'(result.illegal), 16'h0000);
        check_value(16'(result.op), 16'(l));
        check_value(16'(result.mode), 16'(md));
        check_value(16'(result.length), 16'(len));
        check_value(16'(result.cycles), 16'(cyc));
        check_value(16'(result.src), 16'(src));
        check_value(result.effective_address, want);
        check_value(result.program_counter_next, addr + 16'(len));
        check_value(16'(result.is_jump), 16'(branch));
        check_value(16'(result.is_call), 16'(l == 4'hD));
        check_value(16'(result.writes_memory), 16'(store));
        check_value(16'(result.uses_index), 16'(idx_op));
        check_value(16'(result.uses_accumulator), 16'(!idx_op && !branch));
        check_value(16'(result.writes_flags), 16'(!branch));
        check_value(16'(result.writes_register),
            16'(!store && !branch && !flags_only));
        check_value(16'(result.carry_in), 16'((l == 4'h9 || l == 4'h2) && cy));
        if (h == 4'hA) check_value(16'(result.imm), 16'(b1));
        if (branch) check_value(16'(result.uses_accumulator), 16'h0000);
        if (branch) check_value(16'(result.uses_index), 16'h0000);
        if (l == 4'h5) check_value(16'(result.writes_register), 16'h0000);
        if (l == 4'h5) check_value(16'(result.writes_flags), 16'h0001);
        if (l == 4'h9) check_value(16'(result.carry_in), 16'(cy));
        if (l == 4'h9) check_value(16'(result.writes_register), 16'h0001);
    endtask

    // Every opcode of the group, back to back, carry and index varying
    task automatic test_all_forms();
        for (int k = 8'hA0; k <= 8'hFF; k++) begin
            issue(8'(k), {8'(k), ~8'(k)}, 8'(k) ^ 8'h5A, k[0]);
        end
    endtask

    // Address wraps and largest offsets
    task automatic test_boundaries();
        issue(8'hD6, 16'h20FE, 8'hFF, 1'b0);
        issue(8'hE6, 16'h20FE, 8'hFF, 1'b1);
        issue(8'hA6, 16'hFFFF, 8'h00, 1'b0);
        issue(8'hCC, 16'hFFFD, 8'h12, 1'b0);
        issue(8'hBF, 16'h00FE, 8'h00, 1'b1);
    endtask

    // Non-group opcodes and immediate forms that do not exist
    task automatic test_illegal();
        logic [7:0] bad[7] = '{8'h00, 8'h47, 8'h9F, 8'hA7, 8'hAF, 8'hAC, 8'hAD};
        foreach (bad[i]) issue(bad[i], 16'h0100, 8'h01, 1'b0);
    endtask

    // Idle cycle and a reset in mid-run both give an all-zero result
    task automatic test_idle_reset();
        decode_valid = 1'b0;
        @(posedge clock);
        #1;
        check_result(result, '0);
        decode_valid = 1'b1;
        sys_rst = 1'b1;
        @(posedge clock);
        #1;
        check_result(result, '0);
        sys_rst = 1'b0;
        issue(8'hB9, 16'h0300, 8'h00, 1'b1);
        decode_valid = 1'b0;
    endtask

    task automatic stop_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        test_all_forms();
        test_boundaries();
        test_illegal();
        test_idle_reset();
        stop_test();
    end

    // Whole run is about 120 cycles; a stall far beyond that is a hang
    initial begin
        #(2000 * 100);
        fails++;
        stop_test();
    end
endmodule
